// File: tdmvp_pkg.sv
// package of constants and types for the tdm voice port
// Function
// - reset high 1us restores power-up registers
// - open-drain slot indicator low during slot
// - transmit line floats outside assigned slot
// - transmit bits change on bit clock rise
// - receive line ignored outside assigned slot
// - receive bits sampled on bit clock fall
// - non-delayed mode: sync starts own slot
// - delayed mode: counter locates slots
// - signaling output high when signaling active
// - uart lines carry characters in and out
// - frame mode taken from control bit 3
// - slots are eight bits from sync
// - slot indicator low first 7.5 bits
// - slot assignment only in delayed mode
package tdmvp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RESET_HOLD_NS   = 1000;
  localparam int unsigned RESET_HOLD_CYC  = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SLOT_BITS       = 8;

  // ****************************************
  // control register layout and reset values
  // ****************************************
  localparam int unsigned CTRL_DELAYED_BIT = 3;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  TX_BYTE_RESET   = 8'hFF;
  localparam logic [7:0]  SLOT_RESET      = 8'h00;

  typedef enum logic [1:0] {
    TDMVP_IDLE  = 2'b00,
    TDMVP_WAIT  = 2'b01,
    TDMVP_SLOT  = 2'b10
  } tdmvp_state_t;

  // programmable registers of the port
  typedef struct packed {
    logic [7:0] codec_control_reg;
    logic [7:0] slot_num;
    logic [7:0] tx_byte;
  } tdmvp_cfg_t;

  // pin-side link signals after synchronising
  typedef struct packed {
    logic bclk;
    logic fsync;
    logic din;
  } tdmvp_link_t;

endpackage : tdmvp_pkg

// File: tdmvp_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module tdmvp_sync
  import tdmvp_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // signals
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("tdmvp_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } tdmvp_sync_st_t;

  tdmvp_sync_st_t st_q;
  tdmvp_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule // tdmvp_sync
`default_nettype wire

// File: tdmvp_port.sv
// tdm voice port: slot timing, shift registers, indicator and reset stretch
`timescale 1ns/10ps
`default_nettype none
module tdmvp_port
  import tdmvp_pkg::*;
#(
  parameter int unsigned SLOT_COUNT_W = 8
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // module reset pin, active high
  input  wire logic       module_reset,
  // configuration writes from the control side
  input  wire logic       cfg_we,
  input  wire tdmvp_cfg_t cfg_wdata,
  output var  tdmvp_cfg_t cfg_rdata,
  // tdm link
  input  wire logic       bit_clk,
  input  wire logic       frame_sync_in,
  input  wire logic       tdm_in_line,
  output var  logic       tdm_out_line_o,
  output var  logic       tdm_out_line_oe,
  output var  logic       slot_active_n_o,
  output var  logic       slot_active_n_oe,
  // received byte
  output var  logic [7:0] rx_byte,
  output var  logic       rx_valid,
  // signaling and uart
  input  wire logic       signal_active,
  output var  logic       outgoing_signal_flag,
  input  wire logic       uart_rx_line,
  output var  logic       uart_rx_data,
  input  wire logic       uart_tx_data,
  output var  logic       uart_tx_line
);

  if (SLOT_COUNT_W < 3) begin : g_cnt_too_narrow
    $error("tdmvp_port: SLOT_COUNT_W below 3");
  end
  if (SLOT_COUNT_W > 16) begin : g_cnt_too_wide
    $error("tdmvp_port: SLOT_COUNT_W above 16");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  tdmvp_link_t link_s;
  logic        rst_pin_s;
  logic        urx_s;
  logic [4:0]  pin_raw;
  logic [4:0]  pin_s;

  assign pin_raw = {bit_clk, frame_sync_in, tdm_in_line, module_reset, uart_rx_line};

  tdmvp_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // bit clock, sync and data share one chain so their edges stay aligned
  assign link_s    = tdmvp_link_t'(pin_s[4:2]);
  assign rst_pin_s = pin_s[1];
  assign urx_s     = pin_s[0];

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tdmvp_cfg_t             cfg;
    tdmvp_state_t           state;
    logic                   bclk_prev;
    logic                   sync_prev;
    logic [SLOT_COUNT_W-1:0] bit_cnt;
    logic [2:0]             slot_bit;
    logic [7:0]             tx_sh;
    logic [7:0]             rx_sh;
    logic [7:0]             rx_byte;
    logic                   rx_valid;
    logic                   dout;
    logic                   dout_en;
    logic                   ind_low;
    logic [8:0]             rst_cnt;
    logic                   sig;
    logic                   urx;
    logic                   utx;
  } tdmvp_st_t;

  tdmvp_st_t st_q;
  tdmvp_st_t st_d;

  // ****************************************
  // slot timing
  // ****************************************
  logic                    bclk_rise;
  logic                    bclk_fall;
  logic                    sync_rise;
  logic                    delayed_mode;
  logic [SLOT_COUNT_W-1:0] slot_start;

  // edge history resets low like the idle pins, so no false edge follows reset
  assign bclk_rise    = link_s.bclk & ~st_q.bclk_prev;
  assign bclk_fall    = ~link_s.bclk & st_q.bclk_prev;
  assign sync_rise    = link_s.fsync & ~st_q.sync_prev;
  assign delayed_mode = st_q.cfg.codec_control_reg[CTRL_DELAYED_BIT];
  // slot number only counts in delayed mode
  // slots beyond the counter width wrap: size SLOT_COUNT_W to the frame length
  assign slot_start   = delayed_mode ? SLOT_COUNT_W'({st_q.cfg.slot_num, 3'b000}) : '0;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d           = st_q;
    st_d.bclk_prev = link_s.bclk;
    st_d.sync_prev = link_s.fsync;
    st_d.rx_valid  = 1'b0;
    st_d.sig       = signal_active;
    st_d.urx       = urx_s;
    st_d.utx       = uart_tx_data;
    if (cfg_we) begin
      st_d.cfg = cfg_wdata;
    end
    // bit counter restarts each sync, sync marks frame or slot start
    if (sync_rise) begin
      st_d.bit_cnt  = '0;
      st_d.state    = (slot_start == '0) ? TDMVP_SLOT : TDMVP_WAIT;
      st_d.slot_bit = '0;
      st_d.tx_sh    = st_q.cfg.tx_byte;
    end else if (bclk_fall && st_q.state != TDMVP_IDLE) begin
      st_d.bit_cnt = st_q.bit_cnt + 1'b1;
    end
    unique case (st_q.state)
      TDMVP_IDLE: begin
        st_d.dout_en = 1'b0;
      end
      TDMVP_WAIT: begin
        if (!sync_rise && bclk_fall && (st_q.bit_cnt + 1'b1) == slot_start) begin
          st_d.state = TDMVP_SLOT;
        end
      end
      TDMVP_SLOT: begin
        // drive each bit on bit clock rise
        if (bclk_rise) begin
          st_d.dout    = st_q.tx_sh[7];
          st_d.tx_sh   = {st_q.tx_sh[6:0], 1'b1};
          st_d.dout_en = 1'b1;
          st_d.ind_low = 1'b1;
        end
        // sample only inside the slot, on fall
        if (bclk_fall && st_q.dout_en && !sync_rise) begin
          st_d.rx_sh    = {st_q.rx_sh[6:0], link_s.din};
          st_d.slot_bit = st_q.slot_bit + 1'b1;
          if (st_q.slot_bit == 3'(SLOT_BITS - 1)) begin
            st_d.rx_byte  = {st_q.rx_sh[6:0], link_s.din};
            st_d.rx_valid = 1'b1;
            st_d.ind_low  = 1'b0;
          end
        end
        // release the line at the rise after the eighth bit
        if (bclk_rise && st_q.ind_low == 1'b0 && st_q.dout_en) begin
          st_d.state   = TDMVP_IDLE;
          st_d.dout_en = 1'b0;
          st_d.ind_low = 1'b0;
        end
      end
    endcase
    if (sync_rise) begin
      st_d.dout_en = 1'b0;
      st_d.ind_low = 1'b0;
    end
    // module reset pin stretched check: held 1us restores registers
    if (rst_pin_s) begin
      if (st_q.rst_cnt != 9'(RESET_HOLD_CYC)) begin
        st_d.rst_cnt = st_q.rst_cnt + 1'b1;
      end
    end else begin
      st_d.rst_cnt = '0;
    end
    if (rst_pin_s && st_q.rst_cnt >= 9'(RESET_HOLD_CYC - 1)) begin
      st_d.cfg.codec_control_reg = CTRL_RESET;
      st_d.cfg.slot_num          = SLOT_RESET;
      st_d.cfg.tx_byte           = TX_BYTE_RESET;
      st_d.state                 = TDMVP_IDLE;
      st_d.dout_en               = 1'b0;
      st_d.ind_low               = 1'b0;
    end
  end

  // ****************************************
  // register update
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q                       <= '0;
      st_q.cfg.codec_control_reg <= CTRL_RESET;
      st_q.cfg.slot_num          <= SLOT_RESET;
      st_q.cfg.tx_byte           <= TX_BYTE_RESET;
      st_q.state                 <= TDMVP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_rdata            = st_q.cfg;
  assign tdm_out_line_o       = st_q.dout;
  assign tdm_out_line_oe      = st_q.dout_en;
  assign slot_active_n_o      = 1'b0;
  assign slot_active_n_oe     = st_q.ind_low;
  assign rx_byte              = st_q.rx_byte;
  assign rx_valid             = st_q.rx_valid;
  assign outgoing_signal_flag = st_q.sig;
  assign uart_rx_data         = st_q.urx;
  assign uart_tx_line         = st_q.utx;

endmodule // tdmvp_port
`default_nettype wire

// File: tdmvp_port_sva.sv
// assertion checker for the tdm voice port
`timescale 1ns/10ps
`default_nettype none
module tdmvp_port_sva
  import tdmvp_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // watched ports
  input wire logic       cfg_we,
  input wire tdmvp_cfg_t cfg_wdata,
  input wire tdmvp_cfg_t cfg_rdata,
  input wire logic       tdm_out_line_o,
  input wire logic       tdm_out_line_oe,
  input wire logic       slot_active_n_o,
  input wire logic       slot_active_n_oe,
  input wire logic       rx_valid,
  input wire logic       signal_active,
  input wire logic       outgoing_signal_flag,
  input wire logic       uart_tx_data,
  input wire logic       uart_tx_line,
  input wire logic       uart_rx_line,
  input wire logic       uart_rx_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****
  // properties
  // ****
  sequence s_tx_off; ##[1:20] $fell(tdm_out_line_oe); endsequence
  sequence s_rx_done; ##[0:2] rx_valid; endsequence
  property p_od; slot_active_n_oe |-> !slot_active_n_o && tdm_out_line_oe; endproperty
  property p_start; $rose(tdm_out_line_oe) |-> $rose(slot_active_n_oe); endproperty
  property p_ind_rel; $fell(slot_active_n_oe) |-> s_rx_done; endproperty
  property p_end; rx_valid |-> s_tx_off; endproperty
  property p_pulse; rx_valid |=> !rx_valid; endproperty
  property p_sig; 1'b1 |=> outgoing_signal_flag == $past(signal_active); endproperty
  property p_uart; 1'b1 |=> uart_tx_line == $past(uart_tx_data); endproperty
  property p_cfg; cfg_we |=> cfg_rdata == $past(cfg_wdata); endproperty
  property p_urx; 1'b1 |=> ##2 uart_rx_data == $past(uart_rx_line, 3); endproperty
  a_od: assert property (p_od) else $error("indicator pulls outside slot");
  a_start: assert property (p_start) else $error("slot start not paired");
  a_ind_rel: assert property (p_ind_rel) else $error("indicator release early");
  a_end: assert property (p_end) else $error("transmit not released");
  a_pulse: assert property (p_pulse) else $error("receive valid too long");
  a_sig: assert property (p_sig) else $error("signaling flag wrong");
  a_uart: assert property (p_uart) else $error("uart line wrong");
  a_cfg: assert property (p_cfg) else $error("config not loaded");
  a_urx: assert property (p_urx) else $error("uart receive data wrong");
endmodule // tdmvp_port_sva
`default_nettype wire

// File: tdmvp_master.sv
// backplane tdm master model: bit clock, frame sync, receive data
`timescale 1ns/10ps
`default_nettype none
module tdmvp_master (
  // bench control
  input  wire logic       run,
  input  wire logic [1:0] pos,
  input  wire logic [7:0] pat,
  // link
  input  wire logic       tdm_out_line_o,
  input  wire logic       tdm_out_line_oe,
  output var  logic       bit_clk,
  output var  logic       frame_sync_in,
  output var  logic       tdm_in_line,
  // observed transmit side
  output var  logic [7:0] tx_seen,
  output var  logic       stray,
  output var  logic       fdone
);
  logic in_slot;
  initial begin
    {bit_clk, frame_sync_in, tdm_in_line, tx_seen, stray, fdone} = '0;
    forever begin
      @(posedge run);
      #32 frame_sync_in = 1'b1;
      for (int k = 0; k < 33; k++) begin
        in_slot = (k / 8 == pos);
        #32 bit_clk = 1'b1;
        tdm_in_line = in_slot ? pat[7 - k % 8] : ~tdm_in_line;
        #32 bit_clk = 1'b0;
        frame_sync_in = 1'b0;
        // transmit line read on falls, only while driven
        if (tdm_out_line_oe) begin
          tx_seen = {tx_seen[6:0], tdm_out_line_o};
          stray = stray | !in_slot;
        end
      end
      fdone = ~fdone;
    end
  end
endmodule // tdmvp_master
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the tdm voice port
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import tdmvp_pkg::*;
;
  logic mclk, reset_n, module_reset, cfg_we, run, rx_valid, fdone, stray;
  logic signal_active = 1'b0, uart_rx_line = 1'b0, uart_tx_data = 1'b0;
  logic bit_clk, frame_sync_in, tdm_in_line, txo, txe, sao, sae, osf, utl;
  logic [1:0] pos;
  logic [7:0] pat, rx_byte, tx_seen, exp_rx[$], exp_tx[$];
  logic [31:0] rnd = 32'hFA3503E6, rio = 32'hFA3503E6;
  tdmvp_cfg_t cfg_wdata, cfg_rdata, c;
  int errors = 0, cmp_count = 0;
  tdmvp_port tdmvp_port_i (.mclk(mclk), .reset_n(reset_n), .module_reset(module_reset),
    .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .bit_clk(bit_clk),
    .frame_sync_in(frame_sync_in), .tdm_in_line(tdm_in_line), .tdm_out_line_o(txo),
    .tdm_out_line_oe(txe), .slot_active_n_o(sao), .slot_active_n_oe(sae), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .signal_active(signal_active), .outgoing_signal_flag(osf),
    .uart_rx_line(uart_rx_line), .uart_rx_data(), .uart_tx_data(uart_tx_data), .uart_tx_line(utl));
  tdmvp_master tdmvp_master_i (.run(run), .pos(pos), .pat(pat), .tdm_out_line_o(txo),
    .tdm_out_line_oe(txe), .bit_clk(bit_clk), .frame_sync_in(frame_sync_in),
    .tdm_in_line(tdm_in_line), .tx_seen(tx_seen), .stray(stray), .fdone(fdone));
  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input tdmvp_cfg_t v);
    @(posedge mclk) cfg_wdata <= v;
    cfg_we <= 1'b1;
    @(posedge mclk) cfg_we <= 1'b0;
  endtask
  // one frame: note expectations, then let the master run it
  task automatic frm(input logic [1:0] p, input logic [7:0] t, input logic [7:0] r);
    exp_rx.push_back(r);
    exp_tx.push_back(t);
    @(posedge mclk) pos <= p;
    pat <= r;
    run <= 1'b1;
    @(posedge mclk) run <= 1'b0;
    @(fdone);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rio = lf(rio);
    signal_active <= rio[0];
    uart_rx_line <= rio[1];
    uart_tx_data <= rio[2];
  end
  // ****
  // monitors
  // ****
  always @(posedge mclk) if (rx_valid === 1'b1) begin
    if (exp_rx.size() == 0) errors++;
    else check(rx_byte, exp_rx.pop_front());
  end
  always @(fdone) if (exp_tx.size() != 0) check(tx_seen, exp_tx.pop_front());
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    finish_test();
  end
  // ****
  // main sequence
  // ****
  initial begin
    {reset_n, module_reset, cfg_we, run, pos, pat, cfg_wdata} = '0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd = lf(lf(lf(rnd)));
      c.codec_control_reg = i[0] ? 8'h08 : 8'h00;
      c.slot_num = i[0] ? ((i == 1) ? 8'h03 : {6'h00, rnd[9:8]}) : rnd[15:8];
      c.tx_byte = rnd[7:0];
      wr(c);
      frm(i[0] ? c.slot_num[1:0] : 2'h0, rnd[7:0], rnd[23:16]);
    end
    wr('{8'h08, 8'h02, 8'h5A});
    module_reset <= 1'b1;
    repeat (210) @(posedge mclk);
    module_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check(cfg_rdata, {CTRL_RESET, SLOT_RESET, TX_BYTE_RESET});
    frm(2'h0, TX_BYTE_RESET, 8'hC3);
    repeat (20) @(posedge mclk);
    check(stray, 1'b0);
    finish_test();
  end
endmodule // tb_top
bind tdmvp_port tdmvp_port_sva tdmvp_port_sva_i (.*);
`default_nettype wire
